// ---- src/mmsac_core.sv ----
// Internal data space, SFR decode, code and external memory access sequencing
`timescale 1ns/1ps
`default_nettype none
module mmsac_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] bankSel,
    input wire logic idReq,
    input wire logic idWrite,
    input wire logic idIndirect,
    input wire logic idBit,
    input wire logic idRegAccess,
    input wire logic [7:0] idAddr,
    input wire logic [7:0] idWdata,
    output logic idReady,
    output logic idValid_q,
    output logic [7:0] idRdata_q,
    output logic extSfrRead,
    output logic extSfrWrite,
    output logic [7:0] extSfrAddr,
    output logic [7:0] extSfrWdata,
    input wire logic [7:0] extSfrRdata,
    input wire logic codeReq,
    input wire logic [15:0] codeReqAddr,
    input wire logic mxReq,
    input wire logic mxWrite,
    input wire logic mxUseDptr,
    input wire logic [7:0] mxRiValue,
    input wire logic [7:0] mxWdata,
    output logic accReady,
    output logic accDone_q,
    output logic [7:0] accRdata_q,
    output logic [15:0] codeAddr_q,
    output logic codeRd_q,
    output logic codeWr_q,
    output logic [7:0] codeWdata_q,
    input wire logic [7:0] codeRdata,
    output logic [23:0] xAddr_q,
    output logic xRd_q,
    output logic xWr_q,
    output logic [7:0] xWdata_q,
    input wire logic [7:0] xRdata,
    output logic [15:0] activeDataPointer
);
    logic [7:0] pconQ, wtstQ, ckconQ, dpx0Q, dpx1Q, mxaxQ, p2Q, dpsQ;
    logic [7:0] dpl0Q, dph0Q, dpl1Q, dph1Q;
    mmsac_pkg::mmsac_id_e idState_q;
    logic [7:0] tgtAddr_q, tgtAddrD;
    logic tgtSfr_q, tgtSfrD, isBit_q, isWrite_q;
    logic [2:0] bitPos_q;
    logic [7:0] wdata_q;
    logic [7:0] ramAddr, ramRdata, ramWdata, oldByte, newByte, localSfrData;
    logic ramWe, localHit, sfrWe;
    mmsac_pkg::mmsac_acc_e accState_q;
    logic [2:0] accCnt_q;
    logic [15:0] mxLowAddr;

    function automatic logic [2:0] clampWait(input logic [2:0] val, input logic [2:0] floor);
        clampWait = (val < floor) ? floor : val;
    endfunction : clampWait

    function automatic logic [7:0] bitMask(input logic [2:0] pos);
        bitMask = 8'h01 << pos;
    endfunction : bitMask

    // Target decode for the incoming request
    always_comb begin
        tgtAddrD = idAddr;
        tgtSfrD = 1'b0;
        if (idRegAccess) begin
            tgtAddrD = {3'h0, bankSel, idAddr[2:0]};
        end else if (idBit) begin
            if (idAddr[7]) begin
                tgtAddrD = idAddr & mmsac_pkg::BIT_SFR_MASK;
                tgtSfrD = 1'b1;
            end else begin
                tgtAddrD = mmsac_pkg::BIT_AREA_BASE + {4'h0, idAddr[6:3]};
            end
        end else begin
            tgtSfrD = !idIndirect && (idAddr >= mmsac_pkg::UPPER_BASE);
        end
    end

    assign idReady = (idState_q == mmsac_pkg::ID_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            idState_q <= mmsac_pkg::ID_IDLE;
            tgtAddr_q <= 8'h00;
            tgtSfr_q <= 1'b0;
            isBit_q <= 1'b0;
            isWrite_q <= 1'b0;
            bitPos_q <= 3'h0;
            wdata_q <= 8'h00;
        end else begin
            case (idState_q)
                mmsac_pkg::ID_IDLE: begin
                    if (idReq) begin
                        idState_q <= mmsac_pkg::ID_DATA;
                        tgtAddr_q <= tgtAddrD;
                        tgtSfr_q <= tgtSfrD;
                        isBit_q <= idBit;
                        isWrite_q <= idWrite;
                        bitPos_q <= idAddr[2:0];
                        wdata_q <= idWdata;
                    end
                end
                mmsac_pkg::ID_DATA: begin
                    idState_q <= mmsac_pkg::ID_IDLE;
                end
                default: begin
                    idState_q <= mmsac_pkg::ID_IDLE;
                end
            endcase
        end
    end

    // Local SFR read mux; reserved bits read zero
    always_comb begin
        localHit = 1'b1;
        case (tgtAddr_q)
            mmsac_pkg::SFR_DPL0: localSfrData = dpl0Q;
            mmsac_pkg::SFR_DPH0: localSfrData = dph0Q;
            mmsac_pkg::SFR_DPL1: localSfrData = dpl1Q;
            mmsac_pkg::SFR_DPH1: localSfrData = dph1Q;
            mmsac_pkg::SFR_DPS: localSfrData = dpsQ;
            mmsac_pkg::SFR_POWER_AND_CODE_WRITE_CONTROL: localSfrData = pconQ;
            mmsac_pkg::SFR_CLOCK_STRETCH_CONTROL: localSfrData = ckconQ;
            mmsac_pkg::SFR_CODE_WAIT_STATES: localSfrData = wtstQ;
            mmsac_pkg::SFR_POINTER0_UPPER_ADDRESS: localSfrData = dpx0Q;
            mmsac_pkg::SFR_POINTER1_UPPER_ADDRESS: localSfrData = dpx1Q;
            mmsac_pkg::SFR_P2: localSfrData = p2Q;
            mmsac_pkg::SFR_INDIRECT_MOVE_UPPER_ADDRESS: localSfrData = mxaxQ;
            default: begin
                localSfrData = 8'h00;
                localHit = 1'b0;
            end
        endcase
    end

    // Bit writes are read-modify-write on the whole byte
    always_comb begin
        if (!tgtSfr_q) begin
            oldByte = ramRdata;
        end else if (localHit) begin
            oldByte = localSfrData;
        end else begin
            oldByte = extSfrRdata;
        end
        if (isBit_q) begin
            newByte = wdata_q[0] ? (oldByte | bitMask(bitPos_q)) : (oldByte & ~bitMask(bitPos_q));
        end else begin
            newByte = wdata_q;
        end
    end

    wire logic inData = (idState_q == mmsac_pkg::ID_DATA);
    // Whole lower and upper RAM, scratchpad and stack included, in one array
    assign ramAddr = inData ? tgtAddr_q : tgtAddrD;
    assign ramWe = inData && isWrite_q && !tgtSfr_q;
    assign ramWdata = newByte;
    assign sfrWe = inData && isWrite_q && tgtSfr_q && localHit;
    assign extSfrRead = inData && tgtSfr_q && !localHit;
    assign extSfrWrite = inData && isWrite_q && tgtSfr_q && !localHit;
    assign extSfrAddr = tgtAddr_q;
    assign extSfrWdata = newByte;

    mmsac_iram uIram (
        .clk(clk),
        .we(ramWe),
        .addr(ramAddr),
        .wdata(ramWdata),
        .rdata_q(ramRdata)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            idValid_q <= 1'b0;
            idRdata_q <= 8'h00;
        end else begin
            idValid_q <= inData;
            if (inData) begin
                idRdata_q <= isBit_q ? {7'h00, oldByte[bitPos_q]} : oldByte;
            end
        end
    end

    // Local SFR storage
    always_ff @(posedge clk) begin
        if (srst) begin
            pconQ <= mmsac_pkg::POWER_AND_CODE_WRITE_CONTROL_RST;
            wtstQ <= mmsac_pkg::CODE_WAIT_STATES_RST;
            ckconQ <= mmsac_pkg::CLOCK_STRETCH_CONTROL_RST;
            dpx0Q <= mmsac_pkg::DPX_RST;
            dpx1Q <= mmsac_pkg::DPX_RST;
            mxaxQ <= mmsac_pkg::INDIRECT_MOVE_UPPER_ADDRESS_RST;
            p2Q <= mmsac_pkg::P2_RST;
            dpsQ <= mmsac_pkg::DPS_RST;
            dpl0Q <= mmsac_pkg::DP_RST;
            dph0Q <= mmsac_pkg::DP_RST;
            dpl1Q <= mmsac_pkg::DP_RST;
            dph1Q <= mmsac_pkg::DP_RST;
        end else if (sfrWe) begin
            case (tgtAddr_q)
                mmsac_pkg::SFR_DPL0: dpl0Q <= newByte;
                mmsac_pkg::SFR_DPH0: dph0Q <= newByte;
                mmsac_pkg::SFR_DPL1: dpl1Q <= newByte;
                mmsac_pkg::SFR_DPH1: dph1Q <= newByte;
                mmsac_pkg::SFR_DPS: dpsQ <= newByte & mmsac_pkg::DPS_MASK;
                mmsac_pkg::SFR_POWER_AND_CODE_WRITE_CONTROL: pconQ <= newByte & mmsac_pkg::POWER_AND_CODE_WRITE_CONTROL_MASK;
                mmsac_pkg::SFR_CLOCK_STRETCH_CONTROL: ckconQ <= newByte & mmsac_pkg::CLOCK_STRETCH_CONTROL_MASK;
                mmsac_pkg::SFR_CODE_WAIT_STATES: wtstQ <= newByte & mmsac_pkg::CODE_WAIT_STATES_MASK;
                mmsac_pkg::SFR_POINTER0_UPPER_ADDRESS: dpx0Q <= newByte;
                mmsac_pkg::SFR_POINTER1_UPPER_ADDRESS: dpx1Q <= newByte;
                mmsac_pkg::SFR_P2: p2Q <= newByte;
                mmsac_pkg::SFR_INDIRECT_MOVE_UPPER_ADDRESS: mxaxQ <= newByte;
                default: begin
                end
            endcase
        end
    end

    wire logic ptrSel = dpsQ[mmsac_pkg::DPS_SEL_BIT];
    wire logic progWriteEnable = pconQ[mmsac_pkg::PWE_BIT];
    assign activeDataPointer = ptrSel ? {dph1Q, dpl1Q} : {dph0Q, dpl0Q};
    assign mxLowAddr = mxUseDptr ? activeDataPointer : {p2Q, mxRiValue};

    // Pending writes are not queued; the core waits on accReady
    assign accReady = (accState_q == mmsac_pkg::ACC_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            accState_q <= mmsac_pkg::ACC_IDLE;
            accCnt_q <= 3'h0;
            accDone_q <= 1'b0;
            accRdata_q <= 8'h00;
            codeAddr_q <= 16'h0000;
            codeRd_q <= 1'b0;
            codeWr_q <= 1'b0;
            codeWdata_q <= 8'h00;
            xAddr_q <= 24'h000000;
            xRd_q <= 1'b0;
            xWr_q <= 1'b0;
            xWdata_q <= 8'h00;
        end else begin
            accDone_q <= 1'b0;
            case (accState_q)
                mmsac_pkg::ACC_IDLE: begin
                    if (mxReq) begin
                        if (mxWrite && progWriteEnable) begin
                            accState_q <= mmsac_pkg::ACC_CODE_WR;
                            codeAddr_q <= mxLowAddr;
                            codeWdata_q <= mxWdata;
                            codeWr_q <= 1'b1;
                            accCnt_q <= clampWait(ckconQ[2:0], mmsac_pkg::CODE_WR_MIN_WAIT);
                        end else begin
                            accState_q <= mmsac_pkg::ACC_DATA;
                            xAddr_q <= {mxUseDptr ? (ptrSel ? dpx1Q : dpx0Q) : mxaxQ, mxLowAddr};
                            xWdata_q <= mxWdata;
                            xWr_q <= mxWrite;
                            xRd_q <= !mxWrite;
                            accCnt_q <= clampWait(ckconQ[2:0], mmsac_pkg::DATA_MIN_WAIT);
                        end
                    end else if (codeReq) begin
                        accState_q <= mmsac_pkg::ACC_CODE_RD;
                        codeAddr_q <= codeReqAddr;
                        codeRd_q <= 1'b1;
                        accCnt_q <= clampWait(wtstQ[2:0], mmsac_pkg::CODE_RD_MIN_WAIT);
                    end
                end
                mmsac_pkg::ACC_CODE_RD, mmsac_pkg::ACC_DATA, mmsac_pkg::ACC_CODE_WR: begin
                    if (accCnt_q == 3'h0) begin
                        accState_q <= mmsac_pkg::ACC_IDLE;
                        accDone_q <= 1'b1;
                        codeRd_q <= 1'b0;
                        codeWr_q <= 1'b0;
                        xRd_q <= 1'b0;
                        xWr_q <= 1'b0;
                        if (codeRd_q) begin
                            accRdata_q <= codeRdata;
                        end else if (xRd_q) begin
                            accRdata_q <= xRdata;
                        end
                    end else begin
                        accCnt_q <= accCnt_q - 3'h1;
                    end
                end
                default: begin
                    accState_q <= mmsac_pkg::ACC_IDLE;
                end
            endcase
        end
    end
endmodule : mmsac_core
`default_nettype wire

// ---- pkg/mmsac_pkg.sv ----
// Constants and types shared by the memory-space access control block
package mmsac_pkg;
    localparam logic [7:0] SFR_DPL0 = 8'h82;
    localparam logic [7:0] SFR_DPH0 = 8'h83;
    localparam logic [7:0] SFR_DPL1 = 8'h84;
    localparam logic [7:0] SFR_DPH1 = 8'h85;
    localparam logic [7:0] SFR_DPS = 8'h86;
    localparam logic [7:0] SFR_POWER_AND_CODE_WRITE_CONTROL = 8'h87;
    localparam logic [7:0] SFR_CLOCK_STRETCH_CONTROL = 8'h8e;
    localparam logic [7:0] SFR_CODE_WAIT_STATES = 8'h92;
    localparam logic [7:0] SFR_POINTER0_UPPER_ADDRESS = 8'h93;
    localparam logic [7:0] SFR_POINTER1_UPPER_ADDRESS = 8'h95;
    localparam logic [7:0] SFR_P2 = 8'ha0;
    localparam logic [7:0] SFR_INDIRECT_MOVE_UPPER_ADDRESS = 8'hea;

    localparam logic [7:0] POWER_AND_CODE_WRITE_CONTROL_RST = 8'h00;
    localparam logic [7:0] CODE_WAIT_STATES_RST = 8'h07;
    localparam logic [7:0] DPX_RST = 8'h00;
    localparam logic [7:0] INDIRECT_MOVE_UPPER_ADDRESS_RST = 8'h00;
    localparam logic [7:0] CLOCK_STRETCH_CONTROL_RST = 8'h07;
    localparam logic [7:0] P2_RST = 8'h00;
    localparam logic [7:0] DPS_RST = 8'h00;
    localparam logic [7:0] DP_RST = 8'h00;

    localparam logic [7:0] POWER_AND_CODE_WRITE_CONTROL_MASK = 8'hf8;
    localparam logic [7:0] CODE_WAIT_STATES_MASK = 8'h07;
    localparam logic [7:0] CLOCK_STRETCH_CONTROL_MASK = 8'hc7;
    localparam logic [7:0] DPS_MASK = 8'he1;
    localparam int PWE_BIT = 4;
    localparam int DPS_SEL_BIT = 0;

    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] UPPER_BASE = 8'h80;
    localparam logic [7:0] BIT_SFR_MASK = 8'hf8;
    localparam int IRAM_AW = 8;
    localparam int IRAM_DEPTH = 256;

    localparam logic [2:0] CODE_RD_MIN_WAIT = 3'h3;
    localparam logic [2:0] CODE_WR_MIN_WAIT = 3'h3;
    localparam logic [2:0] DATA_MIN_WAIT = 3'h2;

    typedef enum logic [0:0] {
        ID_IDLE = 1'b0,
        ID_DATA = 1'b1
    } mmsac_id_e;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CODE_RD = 2'b01,
        ACC_DATA = 2'b10,
        ACC_CODE_WR = 2'b11
    } mmsac_acc_e;
endpackage : mmsac_pkg

// ---- src/mmsac_iram.sv ----
// Internal data RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module mmsac_iram (
    input wire logic clk,
    input wire logic we,
    input wire logic [mmsac_pkg::IRAM_AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_q
);
    logic [7:0] mem [0:mmsac_pkg::IRAM_DEPTH-1];

    // No reset on the array; contents are undefined until written
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
endmodule : mmsac_iram
`default_nettype wire

// ---- tb/mmsac_core_sva.sv ----
// Port-level assertions for the memory-space access control core
`timescale 1ns/1ps
`default_nettype none
module mmsac_core_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic idReq,
    input wire logic idReady,
    input wire logic idIndirect,
    input wire logic idBit,
    input wire logic idRegAccess,
    input wire logic [7:0] idAddr,
    input wire logic idValid_q,
    input wire logic extSfrRead,
    input wire logic extSfrWrite,
    input wire logic [7:0] extSfrAddr,
    input wire logic mxReq,
    input wire logic mxWrite,
    input wire logic accReady,
    input wire logic accDone_q,
    input wire logic codeRd_q,
    input wire logic codeWr_q,
    input wire logic xRd_q,
    input wire logic xWr_q,
    input wire logic [23:0] xAddr_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_id_answer_two: assert property (idReq && idReady |=> !idReady ##1 idValid_q)
        else $error("internal data answer not two cycles after request");
    a_indirect_ram_only: assert property (idReq && idReady && idIndirect && !idBit && !idRegAccess
        |=> !extSfrRead && !extSfrWrite) else $error("indirect access reached an SFR");
    a_low_ram_only: assert property (idReq && idReady && !idAddr[7] && !idBit
        |=> !extSfrRead && !extSfrWrite) else $error("lower RAM access reached an SFR");
    a_bit_sfr_byte: assert property (idReq && idReady && idBit && idAddr[7]
        |=> !extSfrRead || extSfrAddr == ($past(idAddr) & 8'hf8)) else $error("bit SFR byte wrong");
    a_code_rd_min: assert property ($rose(codeRd_q) |-> codeRd_q[*4])
        else $error("code read strobe shorter than four clocks");
    a_code_rd_max: assert property ($rose(codeRd_q) |-> ##[4:8] !codeRd_q)
        else $error("code read strobe longer than eight clocks");
    a_code_wr_min: assert property ($rose(codeWr_q) |-> codeWr_q[*4])
        else $error("code write strobe shorter than four clocks");
    a_data_len: assert property ($rose(xRd_q || xWr_q) |-> (xRd_q || xWr_q)[*3] ##[1:6] !(xRd_q || xWr_q))
        else $error("data strobe outside three to eight clocks");
    a_done_follows: assert property ($fell(codeRd_q || codeWr_q || xRd_q || xWr_q) |-> accDone_q)
        else $error("access done missing after strobe");
    a_code_wr_cause: assert property ($rose(codeWr_q) |-> $past(mxReq && mxWrite && accReady))
        else $error("code write strobe without a move write");
    a_addr_hold: assert property ($past(xRd_q || xWr_q) && (xRd_q || xWr_q) |-> $stable(xAddr_q))
        else $error("external address moved during strobe");
endmodule : mmsac_core_sva
bind mmsac_core mmsac_core_sva mmsac_core_sva_inst (.clk, .srst, .idReq, .idReady, .idIndirect, .idBit,
    .idRegAccess, .idAddr, .idValid_q, .extSfrRead, .extSfrWrite, .extSfrAddr, .mxReq, .mxWrite, .accReady,
    .accDone_q, .codeRd_q, .codeWr_q, .xRd_q, .xWr_q, .xAddr_q);
`default_nettype wire

// ---- tb/mmsac_mem_model.sv ----
// Code memory and external data memory seen from the core's far side
`timescale 1ns/1ps
`default_nettype none
module mmsac_mem_model (
    input wire logic clk,
    input wire logic [15:0] codeAddr_q,
    input wire logic codeRd_q,
    input wire logic codeWr_q,
    input wire logic [7:0] codeWdata_q,
    output logic [7:0] codeRdata,
    input wire logic [23:0] xAddr_q,
    input wire logic xRd_q,
    input wire logic xWr_q,
    input wire logic [7:0] xWdata_q,
    output logic [7:0] xRdata
);
    logic [7:0] cmem [0:255];
    logic [7:0] xmem [0:255];
    logic [7:0] cLast = 8'h00;
    logic [7:0] xLast = 8'h00;
    initial for (int i = 0; i < 256; i++) begin
        cmem[i] = 8'(i) ^ 8'ha5;
        xmem[i] = 8'(i) + 8'h3c;
    end
    // Released bus shows the inverse of the last value, never a stale copy
    assign codeRdata = codeRd_q ? cmem[codeAddr_q[7:0]] : ~cLast;
    assign xRdata = xRd_q ? xmem[xAddr_q[7:0]] : ~xLast;
    always @(posedge clk) begin
        if (codeRd_q) cLast <= cmem[codeAddr_q[7:0]];
        if (xRd_q) xLast <= xmem[xAddr_q[7:0]];
        if (codeWr_q) cmem[codeAddr_q[7:0]] <= codeWdata_q;
        if (xWr_q) xmem[xAddr_q[7:0]] <= xWdata_q;
    end
endmodule : mmsac_mem_model
`default_nettype wire

// ---- tb/test_mmsac_core.sv ----
// Self-checking bench for the memory-space access control core
`timescale 1ns/1ps
`default_nettype none
module test_mmsac_core;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] bankSel = 2'h0;
    logic idReq = 1'b0, idWrite = 1'b0, idIndirect = 1'b0, idBit = 1'b0, idRegAccess = 1'b0, codeReq = 1'b0;
    logic mxReq = 1'b0, mxWrite = 1'b0, mxUseDptr = 1'b0;
    logic [7:0] idAddr = 8'h00, idWdata = 8'h00, extSfrRdata = 8'h00, mxRiValue = 8'h00, mxWdata = 8'h00;
    logic [15:0] codeReqAddr = 16'h0000;
    logic idReady, idValid_q, extSfrRead, extSfrWrite, accReady, accDone_q, codeRd_q, codeWr_q, xRd_q, xWr_q;
    logic [7:0] idRdata_q, extSfrAddr, extSfrWdata, accRdata_q, codeWdata_q, xWdata_q, codeRdata, xRdata;
    logic [15:0] codeAddr_q, activeDataPointer, dp;
    logic [23:0] xAddr_q, sa;
    int n_errors = 0, checks_done = 0, cyc = 0, k;
    logic [8:0] idQ[$], accQ[$], e9;
    logic [29:0] stQ[$];
    logic [1:0] sk;
    logic [3:0] sw = 4'h0, ws, wc;
    logic [7:0] v, ri, mx, p2, h0, l0, h1, l1, x0, x1, xs;
    always #10 clk = ~clk;
    mmsac_core mmsac_core_inst (.clk, .srst, .bankSel, .idReq, .idWrite, .idIndirect, .idBit, .idRegAccess,
        .idAddr, .idWdata, .idReady, .idValid_q, .idRdata_q, .extSfrRead, .extSfrWrite, .extSfrAddr,
        .extSfrWdata, .extSfrRdata, .codeReq, .codeReqAddr, .mxReq, .mxWrite, .mxUseDptr, .mxRiValue, .mxWdata,
        .accReady, .accDone_q, .accRdata_q, .codeAddr_q, .codeRd_q, .codeWr_q, .codeWdata_q, .codeRdata,
        .xAddr_q, .xRd_q, .xWr_q, .xWdata_q, .xRdata, .activeDataPointer);
    mmsac_mem_model mmsac_mem_model_inst (.clk, .codeAddr_q, .codeRd_q, .codeWr_q, .codeWdata_q, .codeRdata,
        .xAddr_q, .xRd_q, .xWr_q, .xWdata_q, .xRdata);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task conclude();
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task idAcc(input logic w, ind, bt, rg, input logic [7:0] a, d, input logic [8:0] e);
        @(negedge clk);
        {idReq, idWrite, idIndirect, idBit, idRegAccess, idAddr, idWdata} = {1'b1, w, ind, bt, rg, a, d};
        idQ.push_back(e);
        @(negedge clk);
        idReq = 1'b0;
    endtask : idAcc
    task wr(input logic [7:0] a, d);
        idAcc(1'b1, 1'b0, 1'b0, 1'b0, a, d, 9'h000);
    endtask : wr
    task rd(input logic [7:0] a, e);
        idAcc(1'b0, 1'b0, 1'b0, 1'b0, a, 8'h00, {1'b1, e});
    endtask : rd
    // Op 0 code read, 1 move read, 2 move write; waits for the engine to go idle
    task acc(input logic [1:0] op, input logic [15:0] ca, input logic [7:0] d, input logic [29:0] st,
        input logic [8:0] e);
        @(negedge clk);
        {codeReq, mxReq, mxWrite, codeReqAddr, mxWdata} = {op == 2'd0, op != 2'd0, op == 2'd2, ca, d};
        stQ.push_back(st);
        accQ.push_back(e);
        @(negedge clk);
        {codeReq, mxReq} = 2'b00;
        for (int n = 0; n < 12 && accReady !== 1'b1; n++) @(negedge clk);
    endtask : acc
    always @(negedge clk) begin
        if (idValid_q === 1'b1) begin
            e9 = idQ.pop_front();
            if (e9[8]) chk(idRdata_q, e9[7:0]);
        end
        if (accDone_q === 1'b1) begin
            e9 = accQ.pop_front();
            if (e9[8]) chk(accRdata_q, e9[7:0]);
        end
        // Only the direct write to 0x90 reaches an outside SFR
        if (extSfrWrite === 1'b1) chk({extSfrAddr, extSfrWdata}, {8'h90, ~v});
        if ((codeRd_q | codeWr_q | xRd_q | xWr_q) === 1'b1) begin
            sw = sw + 4'h1;
            sk = codeWr_q ? 2'd2 : (codeRd_q ? 2'd1 : 2'd3);
            sa = (sk == 2'd3) ? xAddr_q : {8'h00, codeAddr_q};
        end else if (sw != 4'h0) begin
            chk({sk, sa, sw}, stQ.size() ? stQ.pop_front() : 30'h3fffffff);
            sw = 4'h0;
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'ha071e176));
        extSfrRdata = 8'($urandom);
        repeat (6) @(negedge clk);
        srst = 1'b0;
        rd(8'h87, 8'h00); rd(8'h92, 8'h07); rd(8'h93, 8'h00); rd(8'h95, 8'h00); rd(8'hea, 8'h00);
        wr(8'h87, 8'hff); rd(8'h87, 8'hf8); wr(8'h92, 8'hff); rd(8'h92, 8'h07);
        // Write enable must be clear again, or the first move write lands in code memory
        wr(8'h87, 8'h00);
        for (int b = 0; b < 4; b++) begin
            bankSel = 2'(b);
            v = 8'($urandom);
            k = $urandom_range(7);
            idAcc(1'b1, 1'b0, 1'b0, 1'b1, 8'(k), v, 9'h000);
            rd({3'h0, 2'(b), 3'(k)}, v);
        end
        k = $urandom_range(15);
        ri = 8'($urandom_range(7));
        wr(8'h20 + 8'(k), 8'h00);
        idAcc(1'b1, 1'b0, 1'b1, 1'b0, {1'b0, 4'(k), ri[2:0]}, 8'h01, 9'h000);
        rd(8'h20 + 8'(k), 8'h01 << ri[2:0]);
        idAcc(1'b0, 1'b0, 1'b1, 1'b0, {1'b0, 4'(k), ri[2:0]}, 8'h00, 9'h101);
        v = 8'($urandom);
        ri = 8'($urandom_range(8'h30, 8'h7f));
        wr(ri, v); rd(ri, v + 8'h00);
        // Upper RAM versus SFR; bit SFRs
        idAcc(1'b1, 1'b1, 1'b0, 1'b0, 8'h90, v, 9'h000);
        idAcc(1'b0, 1'b1, 1'b0, 1'b0, 8'h90, 8'h00, {1'b1, v});
        rd(8'h90, extSfrRdata);
        wr(8'h90, ~v);
        idAcc(1'b0, 1'b0, 1'b1, 1'b0, 8'h93, 8'h00, {8'h80, extSfrRdata[3]});
        wr(8'ha0, 8'h00); idAcc(1'b1, 1'b0, 1'b1, 1'b0, 8'ha5, 8'h01, 9'h000); rd(8'ha0, 8'h20);
        // Code read length per wait value
        for (int w = 0; w < 8; w++) begin
            wr(8'h92, 8'(w));
            dp = 16'($urandom);
            acc(2'd0, dp, 8'h00, {2'd1, 8'h00, dp, 4'((w < 3 ? 3 : w) + 1)}, {1'b1, dp[7:0] ^ 8'ha5});
        end
        {l0, l1} = {1'b0, 7'($urandom), 1'b0, 7'($urandom)};
        {h0, h1, x0, x1, mx, p2} = {16'($urandom), 32'($urandom)};
        wr(8'h82, l0); wr(8'h83, h0); wr(8'h84, l1); wr(8'h85, h1);
        wr(8'h93, x0); wr(8'h95, x1); wr(8'hea, mx); wr(8'ha0, p2);
        // Stretch, pointer choice and code writes
        for (int s = 0; s < 8; s++) begin
            wr(8'h8e, 8'(s));
            wr(8'h86, {7'h00, s[0]});
            rd(8'h86, {7'h00, s[0]});
            dp = s[0] ? {h1, l1} : {h0, l0};
            xs = s[0] ? x1 : x0;
            chk(activeDataPointer, dp);
            ws = 4'((s < 2 ? 2 : s) + 1);
            wc = 4'((s < 3 ? 3 : s) + 1);
            v = 8'($urandom);
            ri = {1'b1, 7'($urandom)};
            mxRiValue = ri;
            mxUseDptr = 1'b1;
            acc(2'd1, 16'h0000, 8'h00, {2'd3, xs, dp, ws}, {1'b1, dp[7:0] + 8'h3c});
            mxUseDptr = 1'b0;
            acc(2'd2, 16'h0000, v, {2'd3, mx, p2, ri, ws}, 9'h000);
            // Read back through the same register address so the written data is seen
            acc(2'd1, 16'h0000, 8'h00, {2'd3, mx, p2, ri, ws}, {1'b1, v});
            wr(8'h87, 8'h10);
            mxUseDptr = 1'b1;
            acc(2'd2, 16'h0000, v, {2'd2, 8'h00, dp, wc}, 9'h000);
            acc(2'd0, dp, 8'h00, {2'd1, 8'h00, dp, 4'd8}, {1'b1, v});
            mxUseDptr = 1'b0;
            acc(2'd2, 16'h0000, v, {2'd2, 8'h00, p2, ri, wc}, 9'h000);
            wr(8'h87, 8'h00);
        end
        repeat (12) @(negedge clk);
        chk(idQ.size() + accQ.size() + stQ.size(), 0);
        conclude();
    end
endmodule : test_mmsac_core
`default_nettype wire
